//--- dv/xls_line_net_model.sv
// Behavioural sense network on the mains side of the line-sense pins.
// Assumes the bench gives mains presence and a pin short; one clock.
`timescale 1ns/10ps
`default_nettype none

module xls_line_net_model #(
	parameter int HALF = 50,
	parameter int NEED = 1
) (
	input wire logic mclk,
	input wire logic lineOn,
	input wire logic shorted,
	input wire logic [3:0] sinkStep,
	output logic lineAboveThr,
	output logic pinBelowShortThr
);
	int cnt = 0;
	logic lvl = 1'b0;
	assign lineAboveThr = lvl;
	assign pinBelowShortThr = shorted;
	// Diode leakage hides the mains until the sink step reaches NEED
	always @(posedge mclk) begin
		if (lineOn && !shorted && (sinkStep >> NEED) != 4'h0) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				lvl <= !lvl;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule

`default_nettype wire

//--- dv/xls_line_sense_tb_top.sv
// Self-checking bench for the line-sense sequencer with a mains-side model.
// Assumes the design top and package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module xls_line_sense_tb_top;
	localparam int C = 10;
	localparam int TT[13] = '{10, 12*C, 12*C+10, 24*C, 24*C+10, 36*C, 36*C+10,
		84*C, 84*C+10, 384*C, 384*C+10, 1084*C, 1084*C+10};
	localparam logic [4:0] EE[13] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h04,
		5'h08, 5'h08, 5'h10, 5'h10, 5'h00, 5'h00, 5'h01};
	typedef struct {logic rd; logic [31:0] v;} xls_note_type;
	logic mclk = 0, sysRst = 1, supplyOn = 0, runReq = 0, faultTrip = 0;
	logic lineOn = 0, shorted = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
	logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0, wbDatO, r;
	logic lineAbove, pinBelow, dischargeEn, shortTestSrc, funcDisabled;
	logic lineLossLatch, faultLatch, convSwitchEn, supplyHiccup, irq, wbAck;
	logic [3:0] sinkStep;
	int badCount = 0, nTests = 0, cycN = 0, mark = 0, i, k;
	xls_note_type notes[$];
	xls_note_type mon;

	xls_line_net_model #(.HALF(50), .NEED(1)) net (.mclk(mclk), .lineOn(lineOn),
		.shorted(shorted), .sinkStep(sinkStep), .lineAboveThr(lineAbove),
		.pinBelowShortThr(pinBelow));
	xls_line_sense #(.CYC_PER_MS(C)) dut (.mclk(mclk), .sys_rst(sysRst),
		.lineAboveThr(lineAbove), .pinBelowShortThr(pinBelow), .supplyOn(supplyOn),
		.runReq(runReq), .faultTrip(faultTrip), .sinkStep(sinkStep),
		.dischargeEn(dischargeEn), .shortTestSrc(shortTestSrc),
		.funcDisabled(funcDisabled), .lineLossLatch(lineLossLatch),
		.faultLatch(faultLatch), .convSwitchEn(convSwitchEn),
		.supplyHiccup(supplyHiccup), .irq(irq), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck));

	initial begin
		forever #25 mclk = !mclk;
	end
	always @(posedge mclk) cycN <= cycN + 1;

	task automatic chkPin(input string nm, input logic [3:0] e, input logic [3:0] g);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic till(input int t);
		while (cycN < mark + t) @(posedge mclk);
	endtask
	// For a read, d is the value the register should return
	task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
		xls_note_type n;
		n.rd = !we;
		n.v = d;
		notes.push_back(n);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= 4'hf;
		wbDat <= we ? d : 32'h0;
		do @(posedge mclk); while (wbAck !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		if (wbAck === 1'b1) begin
			if (notes.size() == 0) begin
				badCount++;
				$display("FAIL ack expected 0 seen 1");
			end else begin
				mon = notes.pop_front();
				if (mon.rd) chkWord("read data", mon.v, wbDatO);
			end
		end
	end

	initial begin
		tick(30000);
		badCount++;
		closeOut();
	end

	initial begin
		void'($urandom(91));
		tick(10);
		sysRst <= 1'b0;
		tick(1);
		chkPin("sinkStep", 4'h0, sinkStep);
		chkPin("convSwitchEn", 4'h1, convSwitchEn);
		chkPin("irq", 4'h0, irq);
		bus(1'b0, 4'h0, 32'h1);
		bus(1'b0, 4'h4, 32'h1);
		bus(1'b0, 4'hc, 32'h0);
		bus(1'b0, 4'h6, 32'h0);
		r = $urandom % 16;
		bus(1'b1, 4'hc, r);
		bus(1'b0, 4'hc, r);
		bus(1'b1, 4'hc, 32'h2);
		supplyOn <= 1'b1;
		tick(6);
		chkPin("shortTestSrc", 4'h1, shortTestSrc);
		bus(1'b0, 4'h4, 32'h2);
		runReq <= 1'b1;
		mark = cycN;
		for (i = 0; i < 13; i++) begin
			till(TT[i]);
			chkPin("sinkStep", EE[i][3:0], sinkStep);
			chkPin("dischargeEn", {3'h0, EE[i][4]}, dischargeEn);
			if (i == 8) begin
				chkPin("lineLossLatch", 4'h1, lineLossLatch);
				chkPin("irq", 4'h1, irq);
				bus(1'b0, 4'h8, 32'h2);
				bus(1'b1, 4'hc, 32'h0);
				chkPin("irq", 4'h0, irq);
				bus(1'b1, 4'hc, 32'h2);
				chkPin("irq", 4'h1, irq);
				bus(1'b1, 4'h8, 32'h2);
				chkPin("irq", 4'h0, irq);
				faultTrip <= 1'b1;
				tick(1);
				faultTrip <= 1'b0;
				tick(2);
				chkPin("faultLatch", 4'h1, faultLatch);
				chkPin("convSwitchEn", 4'h0, convSwitchEn);
				chkPin("supplyHiccup", 4'h1, supplyHiccup);
				bus(1'b1, 4'h0, 32'h0);
				chkPin("dischargeEn", 4'h0, dischargeEn);
				bus(1'b1, 4'h0, 32'h1);
				chkPin("dischargeEn", 4'h1, dischargeEn);
			end
		end
		chkPin("faultLatch", 4'h1, faultLatch);
		lineOn <= 1'b1;
		for (k = 0; k < 400 && sinkStep !== 4'h0; k++) tick(1);
		mark = cycN;
		tick(2);
		chkPin("faultLatch", 4'h0, faultLatch);
		chkPin("lineLossLatch", 4'h0, lineLossLatch);
		bus(1'b0, 4'h8, 32'h5);
		till(700 * C - 10);
		chkPin("sinkStep", 4'h0, sinkStep);
		till(700 * C + 10);
		chkPin("sinkStep", 4'h1, sinkStep);
		sysRst <= 1'b1;
		supplyOn <= 1'b0;
		runReq <= 1'b0;
		lineOn <= 1'b0;
		shorted <= 1'b1;
		tick(10);
		sysRst <= 1'b0;
		supplyOn <= 1'b1;
		tick(6);
		runReq <= 1'b1;
		tick(10);
		chkPin("funcDisabled", 4'h1, funcDisabled);
		chkPin("sinkStep", 4'h0, sinkStep);
		chkPin("shortTestSrc", 4'h0, shortTestSrc);
		bus(1'b0, 4'h4, 32'h4040);
		bus(1'b0, 4'h8, 32'h8);
		faultTrip <= 1'b1;
		lineOn <= 1'b1;
		tick(1);
		faultTrip <= 1'b0;
		tick(200);
		chkPin("faultLatch", 4'h1, faultLatch);
		sysRst <= 1'b1;
		tick(10);
		sysRst <= 1'b0;
		tick(1);
		chkPin("faultLatch", 4'h0, faultLatch);
		closeOut();
	end
endmodule

`default_nettype wire

//--- verilog/xls_consts.svh
// Constants for the line-sense sequencer: timing, register map, field positions.
// Included by the package and the design modules; definitions only.
`ifndef XLS_CONSTS_SVH
`define XLS_CONSTS_SVH

`define XLS_CLK_HZ 20000000
`define XLS_MS_PER_S 1000
`define XLS_MS_W 10

// Interval lengths in milliseconds
`define XLS_T_STEP_MS 12
`define XLS_T_LAST_MS 48
`define XLS_T_DETECT_MS 84
`define XLS_T_DISCH_MS 300
`define XLS_T_BLANK_MS 700
`define XLS_T_WAIT_MS 700

`define XLS_LAST_STEP 2'h3
`define XLS_PRE_LAST_STEP 2'h2
`define XLS_FIRST_STEP 2'h0

// Register byte addresses
`define XLS_ADDR_W 4
`define XLS_REG_CTRL 4'h0
`define XLS_REG_STATUS 4'h4
`define XLS_REG_IRQ_STAT 4'h8
`define XLS_REG_IRQ_MASK 4'hc

`define XLS_CTRL_RST 1'h1
`define XLS_IRQ_W 4
`define XLS_IRQ_ZC 0
`define XLS_IRQ_LOSS 1
`define XLS_IRQ_FRST 2
`define XLS_IRQ_SHORT 3

`define XLS_ST_STATE_LSB 0
`define XLS_ST_STEP_LSB 8
`define XLS_ST_LOSS 12
`define XLS_ST_FAULT 13
`define XLS_ST_OFF 14

`endif

//--- verilog/xls_line_sense.sv
// Line-sense sequencer: test-current staircase, line-loss detection,
// bounded capacitor discharge, line-loss latch and fast fault reset.
// Assumes analog comparators and current sources outside; Wishbone slave on mclk.
// How it works
// - Each sense comparator edge is a zero-crossing; edges count only in detect, discharge, blank or wait.
// - 84 ms silence: discharge 300 ms, blank 700 ms.
// - Four sink steps; 12 ms timeout advances first three.
// - Fourth step held 48 ms before discharge.
// - Zero-crossing aborts steps, starts 700 ms wait.
// - Discharge current only after line-loss criteria.
// - Line-loss latch set on confirmed loss; permits discharge.
// - Fault latch stops switching, supply cycles; sequencer runs.
// - Latched line loss plus zero-crossing resets fault.
// - Second staircase step is the 775 uA level.
// - Source 80 uA short test after supply turn-on.
// - Pin low before first run: disable everything.
// - Disabled: fault clears only by logic reset.
`timescale 1ns/10ps
`default_nettype none
`include "xls_consts.svh"

module xls_line_sense #(
	parameter int CYC_PER_MS = `XLS_CLK_HZ / `XLS_MS_PER_S
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic lineAboveThr,
	input wire logic pinBelowShortThr,
	input wire logic supplyOn,
	input wire logic runReq,
	input wire logic faultTrip,
	output logic [3:0] sinkStep,
	output logic dischargeEn,
	output logic shortTestSrc,
	output logic funcDisabled,
	output logic lineLossLatch,
	output logic faultLatch,
	output logic convSwitchEn,
	output logic supplyHiccup,
	output logic irq,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`XLS_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	xls_pkg::seq_state_type state_q;
	logic [1:0] step_q;
	logic lineLoss_q, fault_q, runSeen_q, dischAllow_q, ack_q;
	logic lineS1_q, lineS2_q, lineS3_q, shortS1_q, shortS2_q;
	logic supS1_q, supS2_q, runS1_q, runS2_q;
	logic [`XLS_IRQ_W-1:0] irqStat_q, irqMask_q, irqEv;
	logic [31:0] rdat_q;
	logic zcRaw, zcEv, seqActive, runRise, shortHit, fastReset, wbReq, wbWr;

	xls_tmr_if tmr();

	xls_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.tmr(tmr)
	);

	function automatic logic [3:0] stepOneHot(input logic [1:0] s);
		stepOneHot = 4'h1 << s;
	endfunction

	// Pins from the analog side are asynchronous to mclk
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lineS1_q <= 1'b0;
			lineS2_q <= 1'b0;
			lineS3_q <= 1'b0;
		end else begin
			lineS1_q <= lineAboveThr;
			lineS2_q <= lineS1_q;
			lineS3_q <= lineS2_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			shortS1_q <= 1'b0;
			shortS2_q <= 1'b0;
			supS1_q <= 1'b0;
			supS2_q <= 1'b0;
			runS1_q <= 1'b0;
			runS2_q <= 1'b0;
		end else begin
			shortS1_q <= pinBelowShortThr;
			shortS2_q <= shortS1_q;
			supS1_q <= supplyOn;
			supS2_q <= supS1_q;
			runS1_q <= runReq;
			runS2_q <= runS1_q;
		end
	end

	assign zcRaw = lineS2_q ^ lineS3_q;
	assign seqActive = (state_q == xls_pkg::ST_DETECT) || (state_q == xls_pkg::ST_DISCH)
		|| (state_q == xls_pkg::ST_BLANK) || (state_q == xls_pkg::ST_WAIT);
	assign zcEv = zcRaw && seqActive;
	assign runRise = runS2_q && !runSeen_q;
	assign shortHit = (state_q == xls_pkg::ST_SHORTCHK) && runRise && shortS2_q;

	// Only the first rise of run counts for the short check
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			runSeen_q <= 1'b0;
		end else if (runS2_q) begin
			runSeen_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= xls_pkg::ST_IDLE;
			step_q <= `XLS_FIRST_STEP;
		end else begin
			unique case (state_q)
				xls_pkg::ST_IDLE: begin
					if (supS2_q) begin
						state_q <= xls_pkg::ST_SHORTCHK;
					end
				end
				xls_pkg::ST_SHORTCHK: begin
					if (runRise) begin
						if (shortS2_q) begin
							state_q <= xls_pkg::ST_OFF;
						end else begin
							state_q <= xls_pkg::ST_DETECT;
							step_q <= `XLS_FIRST_STEP;
						end
					end
				end
				xls_pkg::ST_DETECT: begin
					if (zcEv) begin
						state_q <= xls_pkg::ST_WAIT;
					end else if (tmr.expired) begin
						if (step_q != `XLS_LAST_STEP) begin
							step_q <= step_q + 2'h1;
						end else begin
							state_q <= xls_pkg::ST_DISCH;
						end
					end
				end
				xls_pkg::ST_DISCH: begin
					// A returning line ends the discharge early
					if (zcEv) begin
						state_q <= xls_pkg::ST_WAIT;
					end else if (tmr.expired) begin
						state_q <= xls_pkg::ST_BLANK;
					end
				end
				xls_pkg::ST_BLANK, xls_pkg::ST_WAIT: begin
					if (tmr.expired) begin
						state_q <= xls_pkg::ST_DETECT;
						step_q <= `XLS_FIRST_STEP;
					end
				end
				xls_pkg::ST_OFF: begin
					state_q <= xls_pkg::ST_OFF;
				end
			endcase
		end
	end

	// Timer loads on every state or step change that opens an interval
	always_comb begin
		tmr.load = 1'b0;
		tmr.loadMs = '0;
		unique case (state_q)
			xls_pkg::ST_SHORTCHK: begin
				tmr.load = runRise && !shortS2_q;
				tmr.loadMs = `XLS_MS_W'(`XLS_T_STEP_MS);
			end
			xls_pkg::ST_DETECT: begin
				if (zcEv) begin
					tmr.load = 1'b1;
					tmr.loadMs = `XLS_MS_W'(`XLS_T_WAIT_MS);
				end else if (tmr.expired) begin
					tmr.load = 1'b1;
					if (step_q == `XLS_LAST_STEP) begin
						tmr.loadMs = `XLS_MS_W'(`XLS_T_DISCH_MS);
					end else if (step_q == `XLS_PRE_LAST_STEP) begin
						tmr.loadMs = `XLS_MS_W'(`XLS_T_LAST_MS);
					end else begin
						tmr.loadMs = `XLS_MS_W'(`XLS_T_STEP_MS);
					end
				end
			end
			xls_pkg::ST_DISCH: begin
				tmr.load = zcEv || tmr.expired;
				tmr.loadMs = zcEv ? `XLS_MS_W'(`XLS_T_WAIT_MS) : `XLS_MS_W'(`XLS_T_BLANK_MS);
			end
			xls_pkg::ST_BLANK, xls_pkg::ST_WAIT: begin
				tmr.load = tmr.expired;
				tmr.loadMs = `XLS_MS_W'(`XLS_T_STEP_MS);
			end
			xls_pkg::ST_IDLE, xls_pkg::ST_OFF: begin
				tmr.load = 1'b0;
			end
		endcase
	end

	// Line-loss latch: set on entry to discharge, cleared by a zero-crossing
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lineLoss_q <= 1'b0;
		end else if (state_q == xls_pkg::ST_DETECT && step_q == `XLS_LAST_STEP
			&& tmr.expired && !zcEv) begin
			lineLoss_q <= 1'b1;
		end else if (zcEv) begin
			lineLoss_q <= 1'b0;
		end
	end

	assign fastReset = lineLoss_q && zcEv && !faultTrip;

	// A new trip in the same cycle keeps the latch set
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			fault_q <= 1'b0;
		end else if (faultTrip) begin
			fault_q <= 1'b1;
		end else if (fastReset) begin
			fault_q <= 1'b0;
		end
	end

	assign sinkStep = (state_q == xls_pkg::ST_DETECT) ? stepOneHot(step_q) : 4'h0;
	assign dischargeEn = (state_q == xls_pkg::ST_DISCH) && lineLoss_q && dischAllow_q;
	assign shortTestSrc = (state_q == xls_pkg::ST_SHORTCHK);
	assign funcDisabled = (state_q == xls_pkg::ST_OFF);
	assign lineLossLatch = lineLoss_q;
	assign faultLatch = fault_q;
	assign convSwitchEn = !fault_q;
	assign supplyHiccup = fault_q;

	// Wishbone slave, one wait state, unmapped reads return zero
	assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
	assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wbReq;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdat_q <= 32'h00000000;
		end else if (wbReq) begin
			rdat_q <= 32'h00000000;
			unique case (wb_adr_i)
				`XLS_REG_CTRL: rdat_q[0] <= dischAllow_q;
				`XLS_REG_STATUS: begin
					rdat_q[`XLS_ST_STATE_LSB +: 7] <= state_q;
					rdat_q[`XLS_ST_STEP_LSB +: 2] <= step_q;
					rdat_q[`XLS_ST_LOSS] <= lineLoss_q;
					rdat_q[`XLS_ST_FAULT] <= fault_q;
					rdat_q[`XLS_ST_OFF] <= funcDisabled;
				end
				`XLS_REG_IRQ_STAT: rdat_q[`XLS_IRQ_W-1:0] <= irqStat_q;
				`XLS_REG_IRQ_MASK: rdat_q[`XLS_IRQ_W-1:0] <= irqMask_q;
				default: rdat_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dischAllow_q <= `XLS_CTRL_RST;
			irqMask_q <= '0;
		end else if (wbWr && wb_adr_i == `XLS_REG_CTRL) begin
			dischAllow_q <= wb_dat_i[0];
		end else if (wbWr && wb_adr_i == `XLS_REG_IRQ_MASK) begin
			irqMask_q <= wb_dat_i[`XLS_IRQ_W-1:0];
		end
	end

	always_comb begin
		irqEv = '0;
		irqEv[`XLS_IRQ_ZC] = zcEv;
		irqEv[`XLS_IRQ_LOSS] = (state_q == xls_pkg::ST_DETECT) && (step_q == `XLS_LAST_STEP)
			&& tmr.expired && !zcEv;
		irqEv[`XLS_IRQ_FRST] = fastReset && fault_q;
		irqEv[`XLS_IRQ_SHORT] = shortHit;
	end

	// Write-one-to-clear; an event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			irqStat_q <= '0;
		end else if (wbWr && wb_adr_i == `XLS_REG_IRQ_STAT) begin
			irqStat_q <= (irqStat_q & ~wb_dat_i[`XLS_IRQ_W-1:0]) | irqEv;
		end else begin
			irqStat_q <= irqStat_q | irqEv;
		end
	end

	assign irq = |(irqStat_q & irqMask_q);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_disch_needs_loss: assert property (dischargeEn |-> lineLoss_q && state_q == xls_pkg::ST_DISCH)
		else $error("Discharge current without confirmed line loss");
	a_disch_entry: assert property (state_q == xls_pkg::ST_DISCH && $past(state_q) != xls_pkg::ST_DISCH
		|-> $past(state_q) == xls_pkg::ST_DETECT && $past(step_q) == `XLS_LAST_STEP
		&& lineLoss_q)
		else $error("Discharge entered before line-removal criteria");
	a_zc_starts_wait: assert property (state_q == xls_pkg::ST_DETECT && zcEv
		|=> state_q == xls_pkg::ST_WAIT && sinkStep == 4'h0)
		else $error("Zero-crossing did not abort the staircase");
	a_edge_is_zc: assert property (state_q == xls_pkg::ST_DETECT && $rose(lineS2_q)
		|=> state_q == xls_pkg::ST_WAIT)
		else $error("Comparator edge not taken as zero-crossing");
	a_step_advance: assert property (state_q == xls_pkg::ST_DETECT && tmr.expired && !zcEv
		&& step_q != `XLS_LAST_STEP |=> step_q == $past(step_q) + 2'h1)
		else $error("Step timeout did not advance the test current");
	a_last_to_disch: assert property (state_q == xls_pkg::ST_DETECT && step_q == `XLS_LAST_STEP
		&& tmr.expired && !zcEv |=> state_q == xls_pkg::ST_DISCH && lineLoss_q)
		else $error("Last step timeout did not start discharge");
	a_step_load: assert property (state_q == xls_pkg::ST_DETECT && tmr.expired && !zcEv
		&& step_q == `XLS_PRE_LAST_STEP |-> tmr.load
		&& tmr.loadMs == `XLS_MS_W'(`XLS_T_LAST_MS))
		else $error("Fourth step not timed at its long interval");
	a_disch_bounded: assert property (state_q == xls_pkg::ST_DISCH && tmr.expired && !zcEv
		|=> state_q == xls_pkg::ST_BLANK && !dischargeEn)
		else $error("Discharge not followed by blanking");
	a_loss_latched: assert property ($rose(lineLoss_q) |-> state_q == xls_pkg::ST_DISCH)
		else $error("Line-loss latch set outside confirmed loss");
	a_fast_reset: assert property (fault_q && lineLoss_q && zcEv && !faultTrip |=> !fault_q)
		else $error("Fault latch not reset on line return");
	a_fault_stops: assert property (faultTrip |=> !convSwitchEn && supplyHiccup)
		else $error("Fault did not stop switching");
	a_second_step: assert property (state_q == xls_pkg::ST_DETECT && step_q == 2'h1
		|-> sinkStep == 4'h2)
		else $error("Second step current not selected");
	a_short_src: assert property (state_q == xls_pkg::ST_IDLE && supS2_q |=> shortTestSrc)
		else $error("Short test current not sourced after turn-on");
	a_short_off: assert property (shortHit |=> funcDisabled ##1 funcDisabled && sinkStep == 4'h0
		&& !dischargeEn && !shortTestSrc)
		else $error("Shorted pins did not disable the function");
	a_off_no_fast: assert property (funcDisabled && fault_q && !faultTrip |=> fault_q)
		else $error("Fault cleared while line sense disabled");
	a_rearm_low: assert property ((state_q == xls_pkg::ST_WAIT || state_q == xls_pkg::ST_BLANK)
		&& tmr.expired |=> state_q == xls_pkg::ST_DETECT && step_q == `XLS_FIRST_STEP)
		else $error("Detection did not restart at lowest step");

	c_discharge: cover property (state_q == xls_pkg::ST_DETECT ##1 state_q == xls_pkg::ST_DISCH);
	c_fast_reset: cover property (fault_q && fastReset);
	c_short: cover property (shortHit);
	c_wait: cover property (state_q == xls_pkg::ST_WAIT && tmr.expired);
endmodule

`default_nettype wire

//--- verilog/xls_ms_timer.sv
// Millisecond interval timer with its own prescaler.
// Assumes one mclk domain; a load restarts both prescaler and count.
`timescale 1ns/10ps
`default_nettype none
`include "xls_consts.svh"

module xls_ms_timer #(
	parameter int CYC_PER_MS = `XLS_CLK_HZ / `XLS_MS_PER_S
) (
	input wire logic mclk,
	input wire logic sys_rst,
	xls_tmr_if.timer tmr
);
	logic [15:0] preCnt_q;
	xls_pkg::ms_count_type msLeft_q;
	logic msTick;

	// Prescaler restarts on load so every interval is a whole number of ms
	assign msTick = (preCnt_q == 16'(CYC_PER_MS - 1));

	always_ff @(posedge mclk) begin
		if (sys_rst || tmr.load || msTick) begin
			preCnt_q <= 16'h0000;
		end else begin
			preCnt_q <= preCnt_q + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			msLeft_q <= '0;
		end else if (tmr.load) begin
			msLeft_q <= tmr.loadMs;
		end else if (msTick && msLeft_q != '0) begin
			msLeft_q <= msLeft_q - `XLS_MS_W'(1);
		end
	end

	// Expiry ignores load: the sequencer loads on expiry, so gating would close a loop
	assign tmr.expired = msTick && (msLeft_q == `XLS_MS_W'(1));
endmodule

`default_nettype wire

//--- verilog/xls_pkg.sv
// Types shared by the line-sense sequencer modules.
// Assumes xls_consts.svh is on the include path.
`include "xls_consts.svh"

package xls_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_SHORTCHK = 7'h02,
		ST_DETECT = 7'h04,
		ST_DISCH = 7'h08,
		ST_BLANK = 7'h10,
		ST_WAIT = 7'h20,
		ST_OFF = 7'h40
	} seq_state_type;

	typedef logic [`XLS_MS_W-1:0] ms_count_type;
endpackage

//--- verilog/xls_tmr_if.sv
// Carrier between the sequencer and its millisecond interval timer.
// Both ends run on mclk.
`timescale 1ns/10ps
`default_nettype none

interface xls_tmr_if;
	logic load;
	xls_pkg::ms_count_type loadMs;
	logic expired;
	modport ctl(output load, output loadMs, input expired);
	modport timer(input load, input loadMs, output expired);
endinterface

`default_nettype wire
